// [fpd_pkg.sv]
`default_nettype none
package fpd_pkg;
  // reference clock rate
  localparam int CLK_MHZ = 20;
  // opcodes
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_PDOWN  = 8'hb9;
  localparam logic [7:0] OP_RELID  = 8'hab;
  localparam logic [7:0] OP_MID1   = 8'h90;
  localparam logic [7:0] OP_MID2   = 8'h92;
  localparam logic [7:0] OP_MID4   = 8'h94;
  localparam logic [7:0] OP_UID    = 8'h4b;
  // frame geometry, in rising clock edges
  localparam logic [6:0] OP_EDGES    = 7'h08;
  localparam logic [6:0] HDR_ID      = 7'h18;
  localparam logic [6:0] HDR_DUAL_3B = 7'h10;
  localparam logic [6:0] HDR_DUAL_4B = 7'h14;
  localparam logic [6:0] HDR_QUAD_3B = 7'h0c;
  localparam logic [6:0] HDR_QUAD_4B = 7'h0e;
  localparam logic [6:0] HDR_UID_3B  = 7'h20;
  localparam logic [6:0] HDR_UID_4B  = 7'h28;
  localparam logic [6:0] HDR_NONE    = 7'h00;
  localparam logic [6:0] CNT_MAX     = 7'h7f;
  // continuation-mode nibble driven high by the host
  localparam logic [3:0] MODE_HI = 4'hf;
  // times in ns
  localparam int T_BUSY_NS      = 200;
  localparam int T_PD_ENTRY_NS  = 3000;
  localparam int T_REL_PLAIN_NS = 3000;
  localparam int T_REL_ID_NS    = 1800;
  localparam int T_SUSP_LAT_NS  = 20000;
  // cycle counts: longest times round down, least times round up
  localparam int BUSY_CYC      = (T_BUSY_NS * CLK_MHZ) / 1000;
  localparam int PD_ENTRY_CYC  = (T_PD_ENTRY_NS * CLK_MHZ) / 1000;
  localparam int REL_PLAIN_CYC = (T_REL_PLAIN_NS * CLK_MHZ + 999) / 1000;
  localparam int REL_ID_CYC    = (T_REL_ID_NS * CLK_MHZ + 999) / 1000;
  localparam int SUSP_LAT_CYC  = (T_SUSP_LAT_NS * CLK_MHZ + 999) / 1000;

  // frame result handed from the link to the reference domain
  typedef enum logic [2:0] {K_NONE, K_PD, K_RES, K_REL, K_REL_ID} fpd_kind_t;

  // header edges between opcode and first output bit
  function automatic logic [6:0] fpd_hdr(input logic [7:0] op, input logic fb);
    case (op)
      OP_RELID, OP_MID1: fpd_hdr = HDR_ID;
      OP_MID2:           fpd_hdr = fb ? HDR_DUAL_4B : HDR_DUAL_3B;
      OP_MID4:           fpd_hdr = fb ? HDR_QUAD_4B : HDR_QUAD_3B;
      OP_UID:            fpd_hdr = fb ? HDR_UID_4B : HDR_UID_3B;
      default:           fpd_hdr = HDR_NONE;
    endcase
  endfunction

  // data lanes used after the opcode
  function automatic logic [2:0] fpd_lanes(input logic [7:0] op);
    case (op)
      OP_MID2: fpd_lanes = 3'h2;
      OP_MID4: fpd_lanes = 3'h4;
      default: fpd_lanes = 3'h1;
    endcase
  endfunction

  // opcodes that return identification data
  function automatic logic fpd_is_read(input logic [7:0] op);
    fpd_is_read = (op == OP_RELID) || (op == OP_MID1) || (op == OP_MID2) ||
                  (op == OP_MID4) || (op == OP_UID);
  endfunction
endpackage
`default_nettype wire

// [fpd_spi_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface fpd_spi_if;
  logic            cs_n;
  logic            sclk;
  logic      [3:0] h_io;
  logic      [3:0] h_oe;
  logic      [3:0] d_io;
  logic      [3:0] d_oe;
  wire logic [3:0] io;

  // wire level per lane, device first, idle lanes pulled high
  assign io = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe);

  modport host (output cs_n, output sclk, output h_io, output h_oe, input io);
  modport dev  (input cs_n, input sclk, input io, output d_io, output d_oe);
endinterface
`default_nettype wire

// [fpd_host.sv]
`timescale 1ns/100ps
`default_nettype none
module fpd_host
  import fpd_pkg::*;
#(
  parameter int SCLK_HALF = 4
) (
  fpd_spi_if.host         spi,
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_op,
  input  wire logic [6:0] cmd_rx_bits,
  input  wire logic       four_byte,
  output logic            cmd_ready,
  output logic     [63:0] rx_data,
  output logic            rx_valid
);
  typedef enum logic [1:0] {H_IDLE, H_XFER, H_TAIL, H_GAP} fpd_hst_t;

  fpd_hst_t    st;
  logic  [3:0] io_s1;
  logic  [3:0] io_s2;
  logic  [3:0] ph;
  logic  [6:0] edges;
  logic  [6:0] hdr_q;
  logic  [6:0] tot_q;
  logic  [2:0] ln_q;
  logic  [7:0] op_q;
  logic  [6:0] rx_q;
  logic  [8:0] gap;
  logic [63:0] rx_sh;

  // lane drive for the bit cell of rising edge index e
  function automatic logic [7:0] drv(input logic [7:0] op, input logic [6:0] e,
                                     input logic [6:0] hdr, input logic [2:0] ln);
    logic [7:0] sh;
    logic [6:0] h;
    sh = op << e[2:0];
    h  = 7'(e - OP_EDGES);
    drv = 8'h00;
    if (e < OP_EDGES) drv = {4'h1, 3'h0, sh[7]};
    else if (e < 7'(OP_EDGES + hdr)) begin
      if (ln == 3'h2)
        drv = {4'h3, 2'h0, (h >= 7'(hdr - 7'h04) && h < 7'(hdr - 7'h02)) ? 2'h3 : 2'h0};
      else if (ln == 3'h4)
        drv = {4'hf, (h == 7'(hdr - 7'h02)) ? MODE_HI : 4'h0};
      else drv = 8'h10;
    end
  endfunction

  wire       sync_rise  = (ph == 4'(SCLK_HALF - 1));
  wire       take       = cmd_valid && cmd_ready;
  wire [6:0] cmd_hdr    = (cmd_op == OP_RELID && cmd_rx_bits == 7'h00) ?
                          HDR_NONE : fpd_hdr(cmd_op, four_byte);
  wire [2:0] cmd_ln     = fpd_lanes(cmd_op);
  wire [6:0] cmd_rxe    = (cmd_ln == 3'h4) ? (cmd_rx_bits >> 2) :
                          (cmd_ln == 3'h2) ? (cmd_rx_bits >> 1) : cmd_rx_bits;
  wire [7:0] next_drv   = drv(op_q, edges, hdr_q, ln_q);
  wire [7:0] first_drv  = drv(cmd_op, 7'h00, cmd_hdr, cmd_ln);
  wire [3:0] rx_in      = (ln_q == 3'h4) ? io_s2 : (ln_q == 3'h2) ?
                          {2'h0, io_s2[1:0]} : {3'h0, io_s2[1]};
  wire [8:0] gap_load   = (op_q == OP_PDOWN)  ? 9'(PD_ENTRY_CYC) :
                          (op_q == OP_RESUME) ? 9'(SUSP_LAT_CYC) :
                          (op_q == OP_RELID)  ? ((rx_q == 7'h00) ? 9'(REL_PLAIN_CYC) :
                          9'(REL_ID_CYC)) : 9'h001;

  // device data crossing into the reference domain
  always_ff @(posedge ref_clk) begin
    io_s1 <= spi.io;
    io_s2 <= io_s1;
  end

  // frame sequencer and clock divider
  always_ff @(posedge ref_clk) begin
    rx_valid <= 1'b0;
    if (!rst_n) begin
      st        <= H_IDLE;
      spi.cs_n  <= 1'b1;
      spi.sclk  <= 1'b0;
      spi.h_io  <= 4'h0;
      spi.h_oe  <= 4'h0;
      cmd_ready <= 1'b0;
      rx_data   <= 64'h0;
      ph        <= 4'h0;
      edges     <= 7'h00;
      hdr_q     <= 7'h00;
      tot_q     <= 7'h00;
      ln_q      <= 3'h1;
      op_q      <= 8'h00;
      rx_q      <= 7'h00;
      gap       <= 9'h000;
      rx_sh     <= 64'h0;
    end else begin
      unique case (st)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (take) begin
            st        <= H_XFER;
            cmd_ready <= 1'b0;
            spi.cs_n  <= 1'b0;
            {spi.h_oe, spi.h_io} <= first_drv;
            op_q      <= cmd_op;
            hdr_q     <= cmd_hdr;
            ln_q      <= cmd_ln;
            rx_q      <= cmd_rx_bits;
            tot_q     <= 7'(OP_EDGES + cmd_hdr + cmd_rxe);
            edges     <= 7'h00;
            ph        <= 4'h0;
            rx_sh     <= 64'h0;
          end
        end
        H_XFER: begin
          ph <= sync_rise ? 4'h0 : 4'(ph + 4'h1);
          if (sync_rise) begin
            spi.sclk <= ~spi.sclk;
            if (!spi.sclk) begin
              edges <= 7'(edges + 7'h01);
              if (edges >= 7'(OP_EDGES + hdr_q))
                rx_sh <= (rx_sh << ln_q) | {60'h0, rx_in};
            end else if (edges == tot_q) begin
              st <= H_TAIL;
            end else begin
              {spi.h_oe, spi.h_io} <= next_drv;
            end
          end
        end
        H_TAIL: begin
          ph <= sync_rise ? 4'h0 : 4'(ph + 4'h1);
          if (sync_rise) begin
            spi.cs_n <= 1'b1;
            spi.h_oe <= 4'h0;
            spi.h_io <= 4'h0;
            rx_data  <= rx_sh;
            rx_valid <= 1'b1;
            gap      <= gap_load;
            st       <= H_GAP;
          end
        end
        H_GAP: begin
          gap <= 9'(gap - 9'h001);
          if (gap <= 9'h001) st <= H_IDLE;
        end
      endcase
    end
  end
endmodule // fpd_host
`default_nettype wire

// [fpd_dev.sv]
`timescale 1ns/100ps
`default_nettype none
module fpd_dev
  import fpd_pkg::*;
#(
  // identification values, arbitrary
  parameter logic  [7:0] ID_MFR = 8'h5a,
  parameter logic  [7:0] ID_DEV = 8'h18,
  parameter logic [63:0] ID_UID = 64'h0123_4567_89ab_cdef
) (
  fpd_spi_if.dev    spi,
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic four_byte,
  input  wire logic suspend_req,
  input  wire logic op_start,
  input  wire logic op_done,
  input  wire logic power_fail,
  output logic      suspend_flag,
  output logic      busy,
  output logic      powered_down,
  output logic      resume_go
);
  typedef enum logic [1:0] {PW_ON, PW_ENTER, PW_DOWN, PW_WAKE} fpd_pw_t;

  // link domain
  logic      [3:0] fl_s1;
  logic      [3:0] fl_s2;
  logic      [6:0] cnt;
  logic      [6:0] op_sh;
  logic      [7:0] op_q;
  logic            rd_on;
  logic            out_on;
  logic            started;
  logic     [63:0] sr;
  fpd_kind_t       kind;
  // reference domain
  logic      [2:0] cs_s;
  fpd_kind_t       k_s1;
  fpd_kind_t       k_s2;
  fpd_pw_t         pw;
  fpd_pw_t         next_pw;
  logic     [11:0] tmr;
  logic     [11:0] next_tmr;
  logic      [2:0] bdly;
  logic            lock_q;
  logic            fb_q;

  // flags as seen by the link, settled well before the eighth edge
  wire       lock_s = fl_s2[3];
  wire       pd_s   = fl_s2[2];
  wire       busy_s = fl_s2[1];
  wire       fb_s   = fl_s2[0];

  // opcode decode on the eighth rising edge
  wire [7:0] opcode = {op_sh, spi.io[0]};
  wire       at_op  = (cnt == 7'h07);
  wire       is_rel = (opcode == OP_RELID);
  wire       rd_ok  = fpd_is_read(opcode) && !lock_s && (!pd_s || is_rel) &&
                      !(is_rel && busy_s);
  fpd_kind_t next_kind;
  assign next_kind = lock_s ? K_NONE :
                     pd_s ? (is_rel ? K_REL : K_NONE) :
                     (opcode == OP_PDOWN) ? K_PD :
                     (opcode == OP_RESUME) ? K_RES : K_NONE;

  // first output bit follows the last header edge
  wire [6:0] start_e = 7'(OP_EDGES + fpd_hdr(op_q, fb_s));
  wire [2:0] lanes   = fpd_lanes(op_q);
  wire [63:0] id_word = (op_q == OP_UID) ? ID_UID :
                        (op_q == OP_RELID) ? {8{ID_DEV}} :
                        {4{ID_MFR, ID_DEV}};
  wire [63:0] cur     = started ? sr : id_word;
  wire [63:0] rot     = (lanes == 3'h4) ? {cur[59:0], cur[63:60]} :
                        (lanes == 3'h2) ? {cur[61:0], cur[63:62]} :
                        {cur[62:0], cur[63]};
  wire  [3:0] top     = (lanes == 3'h4) ? cur[63:60] :
                        (lanes == 3'h2) ? {2'h0, cur[63:62]} : {2'h0, cur[63], 1'b0};
  wire  [3:0] oe_mask = (lanes == 3'h4) ? 4'hf : (lanes == 3'h2) ? 4'h3 : 4'h2;

  // reference-domain flags into the link clock
  always_ff @(posedge spi.sclk) begin
    fl_s1 <= {lock_q, powered_down, busy, fb_q};
    fl_s2 <= fl_s1;
  end

  // input shifter and edge count, cleared while deselected
  always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      cnt    <= 7'h00;
      op_sh  <= 7'h00;
      op_q   <= 8'h00;
      rd_on  <= 1'b0;
      out_on <= 1'b0;
    end else begin
      if (cnt != CNT_MAX) cnt <= 7'(cnt + 7'h01);
      op_sh <= {op_sh[5:0], spi.io[0]};
      if (at_op) begin
        op_q  <= opcode;
        rd_on <= rd_ok;
      end
      if (rd_on && cnt == 7'(start_e - 7'h01)) out_on <= 1'b1;
    end
  end

  // frame outcome, held across deselect for the other domain
  always_ff @(posedge spi.sclk) begin
    if (cnt == 7'h00) kind <= K_NONE;
    else if (at_op) kind <= next_kind;
    else if (cnt == OP_EDGES && kind == K_REL) kind <= K_REL_ID;
    else if (cnt == OP_EDGES) kind <= K_NONE;
  end

  // identification output on falling edges
  always_ff @(negedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      spi.d_io <= 4'h0;
      spi.d_oe <= 4'h0;
      sr       <= 64'h0;
      started  <= 1'b0;
    end else if (out_on) begin
      started  <= 1'b1;
      sr       <= rot;
      spi.d_io <= top;
      spi.d_oe <= oe_mask;
    end
  end

  // select and frame result into the reference clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_s <= 3'h7;
      k_s1 <= K_NONE;
      k_s2 <= K_NONE;
    end else begin
      cs_s <= {cs_s[1:0], spi.cs_n};
      k_s1 <= kind;
      k_s2 <= k_s1;
    end
  end

  wire cs_rise  = cs_s[1] && !cs_s[2];
  wire susp_ok  = suspend_req && !suspend_flag && busy;
  wire res_ok   = cs_rise && k_s2 == K_RES && suspend_flag && !busy &&
                  pw == PW_ON;
  wire bfire    = (bdly == 3'h1);

  // power state sequencing
  always_comb begin
    next_pw  = pw;
    next_tmr = (tmr != 12'h000) ? 12'(tmr - 12'h001) : 12'h000;
    unique case (pw)
      PW_ON: begin
        if (cs_rise && k_s2 == K_PD) begin
          next_pw  = PW_ENTER;
          next_tmr = 12'(PD_ENTRY_CYC - 1);
        end
      end
      PW_ENTER: begin
        if (tmr == 12'h000) next_pw = PW_DOWN;
      end
      PW_DOWN: begin
        if (cs_rise && k_s2 == K_REL) begin
          next_pw  = PW_WAKE;
          next_tmr = 12'(REL_PLAIN_CYC - 1);
        end else if (cs_rise && k_s2 == K_REL_ID) begin
          next_pw  = PW_WAKE;
          next_tmr = 12'(REL_ID_CYC - 1);
        end
      end
      PW_WAKE: begin
        if (tmr == 12'h000) next_pw = PW_ON;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pw           <= PW_ON;
      tmr          <= 12'h000;
      powered_down <= 1'b0;
      lock_q       <= 1'b0;
      fb_q         <= 1'b0;
    end else begin
      pw           <= next_pw;
      tmr          <= next_tmr;
      powered_down <= (next_pw == PW_DOWN);
      lock_q       <= (next_pw == PW_ENTER) || (next_pw == PW_WAKE);
      fb_q         <= four_byte;
    end
  end

  // suspend flag, busy flag and delayed resume of the engine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      suspend_flag <= 1'b0;
      busy         <= 1'b0;
      bdly         <= 3'h0;
      resume_go    <= 1'b0;
    end else begin
      resume_go <= bfire && !power_fail;
      if (susp_ok) suspend_flag <= 1'b1;
      else if (res_ok || power_fail) suspend_flag <= 1'b0;
      if (power_fail) bdly <= 3'h0;
      else if (res_ok) bdly <= 3'(BUSY_CYC);
      else if (bdly != 3'h0) bdly <= 3'(bdly - 3'h1);
      if (op_start || (bfire && !power_fail)) busy <= 1'b1;
      else if (op_done || susp_ok || power_fail) busy <= 1'b0;
    end
  end
endmodule // fpd_dev
`default_nettype wire

// [fpd_check_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module fpd_check_sva
  import fpd_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] d_oe,
  input wire logic       suspend_req,
  input wire logic       op_start,
  input wire logic       power_fail,
  input wire logic       suspend_flag,
  input wire logic       busy,
  input wire logic       powered_down,
  input wire logic       resume_go
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [9:0] hi_cnt;

  // cycles with select high, saturating, so entry delay can be bounded
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cs_n) begin
      hi_cnt <= cs_n ? 10'h3ff : 10'h000;
    end else if (hi_cnt != 10'h3ff) begin
      hi_cnt <= hi_cnt + 10'h001;
    end
  end

  reset_flags_a: assert property ($rose(rst_n) |-> !powered_down && !busy && !suspend_flag)
    else $error("flags not clear after reset");
  resume_clear_a: assert property ($fell(suspend_flag) && !$past(power_fail)
    |-> !busy ##4 (busy && resume_go)) else $error("resume busy timing wrong");
  resume_ok_a: assert property ($rose(resume_go) |-> !$past(busy) && $past(suspend_flag, 5))
    else $error("resume without suspended idle state");
  go_pulse_a: assert property (resume_go |=> !resume_go)
    else $error("resume pulse too long");
  power_fail_a: assert property (power_fail && !op_start && !suspend_req
    |=> !suspend_flag && !busy && !resume_go) else $error("power loss left state");
  suspend_set_a: assert property (suspend_req && !power_fail |=> suspend_flag)
    else $error("suspend flag not set");
  dev_quiet_a: assert property (cs_n |-> d_oe == 4'h0)
    else $error("device drives while deselected");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("clock not idle low");
  pd_entry_a: assert property ($rose(powered_down)
    |-> hi_cnt >= 10'(PD_ENTRY_CYC) && hi_cnt <= 10'(PD_ENTRY_CYC + 6))
    else $error("entry time off");

  // main scenarios reached
  cover property ($rose(resume_go));
  cover property ($rose(powered_down));
  cover property ($fell(powered_down));
  cover property (!cs_n && d_oe == 4'hf);
endmodule // fpd_check_sva
`default_nettype wire

// [fpd_test.sv]
`timescale 1ns/100ps
`default_nettype none
module fpd_test;
  import fpd_pkg::*;
  // identification values, arbitrary
  localparam logic [7:0]  M    = 8'h3c;
  localparam logic [7:0]  D    = 8'h19;
  localparam logic [63:0] U    = 64'hfeed_0bad_1234_5678;
  localparam logic [63:0] ONES = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0]  ops [5] = '{OP_RELID, OP_MID1, OP_MID2, OP_MID4, OP_UID};

  logic        ref_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        cmd_valid   = 1'b0;
  logic [7:0]  cmd_op      = 8'h00;
  logic [6:0]  cmd_rx_bits = 7'h00;
  logic        four_byte   = 1'b0;
  logic [3:0]  ev          = 4'h0;
  logic        cmd_ready, rx_valid, suspend_flag, busy, powered_down, resume_go;
  logic [63:0] rx_data;
  logic [64:0] notes [$];
  logic [64:0] note;
  int          fails = 0, tests_run = 0, cycles = 0, n_go = 0, k, seed = 32'h567f205c;

  fpd_spi_if spi ();
  fpd_host i_fpd_host (.spi(spi), .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_rx_bits(cmd_rx_bits), .four_byte(four_byte),
    .cmd_ready(cmd_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  fpd_dev #(.ID_MFR(M), .ID_DEV(D), .ID_UID(U)) i_fpd_dev (.spi(spi), .ref_clk(ref_clk),
    .rst_n(rst_n), .four_byte(four_byte), .suspend_req(ev[0]), .op_start(ev[1]),
    .op_done(ev[2]), .power_fail(ev[3]), .suspend_flag(suspend_flag), .busy(busy),
    .powered_down(powered_down), .resume_go(resume_go));
  fpd_check_sva i_fpd_check_sva (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(spi.cs_n),
    .sclk(spi.sclk), .d_oe(spi.d_oe), .suspend_req(ev[0]), .op_start(ev[1]),
    .power_fail(ev[3]), .suspend_flag(suspend_flag), .busy(busy),
    .powered_down(powered_down), .resume_go(resume_go));

  always #25 ref_clk = ~ref_clk;

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  // state is suspend, busy, powered down, low bits of resume pulse count
  task automatic cmp_state(input logic [4:0] exp);
    tests_run++;
    if ({suspend_flag, busy, powered_down, 2'(n_go)} !== exp) begin
      fails++;
      $display("wrong value at %0t: state %b, expected %b", $time,
               {suspend_flag, busy, powered_down, 2'(n_go)}, exp);
    end
  endtask

  // one frame through the host port, expected read noted first
  task automatic send(input logic [7:0] op, input logic [6:0] bits, input logic [64:0] nt);
    int w;
    notes.push_back(nt);
    @(negedge ref_clk);
    cmd_op = op;
    cmd_rx_bits = bits;
    cmd_valid = 1'b1;
    for (w = 0; w < 3000 && cmd_ready !== 1'b1; w++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (w = 0; w < 3000 && cmd_ready !== 1'b1; w++) @(negedge ref_clk);
    if (cmd_ready !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: host port stuck", $time);
    end
    repeat (8) @(negedge ref_clk);
  endtask

  // one-cycle pulse on the engine side inputs
  task automatic ev_pulse(input logic [3:0] m);
    @(negedge ref_clk);
    ev = m;
    @(negedge ref_clk);
    ev = 4'h0;
    repeat (6) @(negedge ref_clk);
  endtask

  function automatic logic [63:0] id_exp(input logic [7:0] op);
    case (op)
      OP_RELID: id_exp = {8{D}};
      OP_UID:   id_exp = U;
      default:  id_exp = {4{M, D}};
    endcase
  endfunction

  // hang guard and resume pulse counter
  always @(posedge ref_clk) begin
    cycles++;
    if (resume_go === 1'b1) n_go++;
    if (cycles == 90000) begin
      fails++;
      $display("wrong value at %0t: run timed out", $time);
      finish_test();
    end
  end

  // read monitor: oldest note against each delivered read
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("wrong value at %0t: read with nothing expected", $time);
      end else begin
        note = notes.pop_front();
        if (note[64]) cmp_data(rx_data, note[63:0]);
      end
    end
  end

  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp_state(5'h00);
    $display("reset test done");
    for (int f = 0; f < 2; f++) begin
      four_byte = f[0];
      foreach (ops[i]) send(ops[i], 7'h40, {1'b1, id_exp(ops[i])});
    end
    four_byte = 1'b0;
    $display("id read test done");
    send(OP_PDOWN, 7'h40, {1'b1, ONES});
    cmp_state(5'h00);
    send(OP_PDOWN, 7'h00, 65'h0);
    cmp_state(5'h04);
    send(OP_MID1, 7'h40, {1'b1, ONES});
    send(OP_RELID, 7'h00, 65'h0);
    cmp_state(5'h00);
    send(OP_PDOWN, 7'h00, 65'h0);
    cmp_state(5'h04);
    send(OP_RELID, 7'h40, {1'b1, {8{D}}});
    cmp_state(5'h00);
    $display("power-down test done");
    ev_pulse(4'h2);
    ev_pulse(4'h1);
    cmp_state(5'h10);
    ev_pulse(4'h2);
    send(OP_RESUME, 7'h00, 65'h0);
    cmp_state(5'h18);
    ev_pulse(4'h4);
    send(OP_RESUME, 7'h00, 65'h0);
    cmp_state(5'h09);
    send(OP_RELID, 7'h40, {1'b1, ONES});
    cmp_state(5'h09);
    ev_pulse(4'h4);
    send(OP_RESUME, 7'h00, 65'h0);
    cmp_state(5'h01);
    ev_pulse(4'h2);
    ev_pulse(4'h1);
    ev_pulse(4'h8);
    send(OP_RESUME, 7'h00, 65'h0);
    cmp_state(5'h01);
    $display("resume test done");
    repeat (6) begin
      k = $unsigned($random(seed)) % 5;
      four_byte = 1'($random(seed));
      send(ops[k], 7'h40, {1'b1, id_exp(ops[k])});
    end
    $display("random read test done");
    if (notes.size() != 0) begin
      fails++;
      $display("wrong value at %0t: reads missing", $time);
    end
    finish_test();
  end
endmodule // fpd_test
`default_nettype wire
